// *** logic/fplc_pkg.sv ***
// Constants, offsets and state codes of the format parameter list checker.
// Assumes one clock domain and a plain register port with 32-bit data.
package fplc_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] REG_CFG = 8'h00;
   localparam logic [7:0] REG_MAX_LBA = 8'h04;
   localparam logic [7:0] REG_MAX_CYL = 8'h08;
   localparam logic [7:0] REG_MAX_HEAD = 8'h0c;
   localparam logic [7:0] REG_MAX_SECTOR = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [3:0] CFG_BLK_LOG2_RST = 4'h9;
   localparam logic [31:0] MAX_LBA_RST = 32'hffffffff;
   localparam logic [23:0] MAX_CYL_RST = 24'hffffff;
   localparam logic [7:0] MAX_HEAD_RST = 8'hff;
   localparam logic [31:0] MAX_SECTOR_RST = 32'hffffffff;
   // ==========================================================
   // Field codes
   localparam logic [2:0] DFMT_BLOCK = 3'h0;
   localparam logic [2:0] DFMT_BYTES = 3'h4;
   localparam logic [2:0] DFMT_PHYS = 3'h5;
   localparam logic [7:0] PAT_DEFAULT = 8'h00;
   localparam logic [7:0] PAT_REPEAT = 8'h01;
   localparam logic [1:0] PROT_T0 = 2'h0;
   localparam logic [1:0] PROT_T1 = 2'h1;
   localparam logic [1:0] PROT_T2 = 2'h2;
   localparam logic [3:0] PIE_4K = 4'h3;
   localparam logic [3:0] BLK_LOG2_4K = 4'hc;
   localparam logic [10:0] MAX_DESCS = 11'h400;
   localparam logic [3:0] DESC_BLOCK_BYTES = 4'h4;
   localparam logic [3:0] DESC_WIDE_BYTES = 4'h8;
   localparam logic [2:0] PAT_HDR_BYTES = 3'h4;
   localparam logic [3:0] SK_ILLEGAL_REQUEST = 4'h5;
   localparam logic [7:0] ASC_INV_FIELD_PLIST = 8'h26;
   // ==========================================================
   // Sequencer states
   typedef enum logic [7:0] {
      ST_IDLE = 8'b0000_0001,
      ST_PAT_HDR = 8'b0000_0010,
      ST_PAT_DATA = 8'b0000_0100,
      ST_DEFECT = 8'b0000_1000,
      ST_DRAIN = 8'b0001_0000,
      ST_REPLAY = 8'b0010_0000,
      ST_FORMAT = 8'b0100_0000,
      ST_REPORT = 8'b1000_0000
   } fplc_state_t;
endpackage

// *** logic/fplc_checker.sv ***
// Format parameter list checker: checks the pattern descriptor, protection
// settings and defect list, then replays accepted defects and runs the format.
// Assumes header fields decoded upstream and the byte stream on ref_clk_in.
//
// Contract
// - type 0 default fill, type 1 repeats pattern
// - type 0 with nonzero length is illegal
// - type 1 with zero length is illegal
// - save mode parameters unless disable-save set
// - immediate flag returns status after data out
// - failed immediate format makes deferred error
// - type 1 with nonzero exponent is illegal
// - type 2 interval is block length shifted
// - exponent 0 always, 3 only 4096 blocks
// - defect length counts descriptor bytes only
// - at most 1024 defect descriptors accepted
// - length equals four or eight times count
// - descriptors accepted in any order
// - non addressable location is illegal
// - block code holds four-byte big-endian LBA
// - bytes-from-index marks sector holding byte
// - physical sector code marks addressed sector
// - skip-primary drops descriptors found in factory list
// - skip-primary stops factory list use, keeps it
// - pattern flag expects descriptor, else zero fill
`timescale 1ns/1ns
module fplc_checker (
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   input wire logic start_in,
   input wire logic param_list_present_flag_in,
   input wire logic pattern_descriptor_flag_in,
   input wire logic skip_primary_list_flag_in,
   input wire logic disable_save_in,
   input wire logic immed_in,
   input wire logic [1:0] prot_type_in,
   input wire logic [3:0] interval_exp_in,
   input wire logic [2:0] dlist_fmt_in,
   input wire logic [15:0] dlist_len_in,
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   input wire logic byte_last_in,
   input wire logic plist_hit_in,
   input wire logic format_done_in,
   input wire logic format_fail_in,
   output logic pattern_mode_out,
   output logic [15:0] pattern_len_out,
   output logic pattern_byte_valid_out,
   output logic [7:0] pattern_byte_out,
   output logic [15:0] pi_interval_out,
   output logic defect_valid_out,
   output logic [2:0] defect_fmt_out,
   output logic [63:0] defect_key_out,
   output logic grown_add_out,
   output logic use_plist_out,
   output logic save_params_out,
   output logic format_start_out,
   output logic status_valid_out,
   output logic check_cond_out,
   output logic [3:0] sense_key_out,
   output logic [7:0] asc_out,
   output logic deferred_err_out
);
   import fplc_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic [3:0] desc_bytes(input logic [2:0] fmt);
      desc_bytes = (fmt == DFMT_BLOCK) ? DESC_BLOCK_BYTES : DESC_WIDE_BYTES;
   endfunction

   function automatic logic fmt_ok(input logic [2:0] fmt);
      fmt_ok = (fmt == DFMT_BLOCK) || (fmt == DFMT_BYTES) || (fmt == DFMT_PHYS);
   endfunction

   // ==========================================================
   // Registers
   logic [3:0] blk_log2, next_blk_log2;
   logic [31:0] max_lba, next_max_lba;
   logic [23:0] max_cyl, next_max_cyl;
   logic [7:0] max_head, next_max_head;
   logic [31:0] max_sector, next_max_sector;
   logic [31:0] next_reg_rdata;
   fplc_state_t state, next_state;
   logic err, next_err;
   logic [10:0] desc_cnt, next_desc_cnt;

   always_comb begin
      {next_blk_log2, next_max_cyl, next_max_head} = {blk_log2, max_cyl, max_head};
      {next_max_lba, next_max_sector} = {max_lba, max_sector};
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            REG_CFG: next_blk_log2 = reg_wdata_in[3:0];
            REG_MAX_LBA: next_max_lba = reg_wdata_in;
            REG_MAX_CYL: next_max_cyl = reg_wdata_in[23:0];
            REG_MAX_HEAD: next_max_head = reg_wdata_in[7:0];
            REG_MAX_SECTOR: next_max_sector = reg_wdata_in;
            default: ;
         endcase
      end
      next_reg_rdata = 32'h0;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            REG_CFG: next_reg_rdata = {28'h0, blk_log2};
            REG_MAX_LBA: next_reg_rdata = max_lba;
            REG_MAX_CYL: next_reg_rdata = {8'h0, max_cyl};
            REG_MAX_HEAD: next_reg_rdata = {24'h0, max_head};
            REG_MAX_SECTOR: next_reg_rdata = max_sector;
            REG_STATUS: next_reg_rdata = {11'h0, desc_cnt, 1'b0, err, state};
            default: next_reg_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         {blk_log2, max_cyl, max_head} <= {CFG_BLK_LOG2_RST, MAX_CYL_RST, MAX_HEAD_RST};
         {max_lba, max_sector} <= {MAX_LBA_RST, MAX_SECTOR_RST};
         reg_rdata_out <= 32'h0;
      end else begin
         {blk_log2, max_cyl, max_head} <= {next_blk_log2, next_max_cyl, next_max_head};
         {max_lba, max_sector} <= {next_max_lba, next_max_sector};
         reg_rdata_out <= next_reg_rdata;
      end
   end

   // ==========================================================
   // Sequencer
   logic [63:0] desc_mem [0:1023];
   logic [63:0] acc, next_acc;
   logic [15:0] byte_cnt, next_byte_cnt;
   logic [15:0] remain, next_remain;
   logic [10:0] rep_idx, next_rep_idx;
   logic rep_phase, next_rep_phase;
   logic skip_pl, next_skip_pl;
   logic imm, next_imm;
   logic [2:0] dfmt, next_dfmt;
   logic mem_we;
   logic [63:0] mem_wdata;
   logic [15:0] blk_len;
   logic [3:0] dbytes;
   logic [15:0] plen_now;
   logic [63:0] desc_now;
   logic [63:0] rd_desc;
   logic desc_bad;
   logic [31:0] off_sector;
   logic next_pattern_mode, next_pat_bv, next_defect_valid, next_grown_add;
   logic next_format_start, next_status_valid, next_check_cond, next_deferred;
   logic next_save, next_use_plist;
   logic [15:0] next_pattern_len, next_pi_interval;
   logic [7:0] next_pat_byte;
   logic [63:0] next_defect_key;

   always_comb begin
      blk_len = 16'h1 << blk_log2;
      dbytes = desc_bytes(dfmt);
      desc_now = {acc[55:0], byte_in};
      rd_desc = desc_mem[rep_idx[9:0]];
      off_sector = desc_now[31:0] >> blk_log2;
      desc_bad = (desc_now[63:40] > max_cyl) || (desc_now[39:32] > max_head);
      unique case (dfmt)
         DFMT_BLOCK: desc_bad = desc_now[31:0] > max_lba;
         DFMT_BYTES: desc_bad = desc_bad || (off_sector > max_sector);
         default: desc_bad = desc_bad || (desc_now[31:0] > max_sector);
      endcase
      plen_now = {acc[7:0], byte_in};
      next_state = state;
      next_err = err;
      next_acc = acc;
      next_byte_cnt = byte_cnt;
      next_remain = remain;
      next_desc_cnt = desc_cnt;
      {next_rep_idx, next_rep_phase} = {rep_idx, rep_phase};
      {next_skip_pl, next_imm, next_dfmt} = {skip_pl, imm, dfmt};
      {mem_we, mem_wdata} = 65'h0;
      next_pattern_mode = pattern_mode_out;
      next_pattern_len = pattern_len_out;
      next_pi_interval = pi_interval_out;
      {next_pat_bv, next_defect_valid, next_grown_add} = 3'h0;
      {next_format_start, next_status_valid, next_deferred} = 3'h0;
      next_pat_byte = pattern_byte_out;
      next_defect_key = defect_key_out;
      next_check_cond = check_cond_out;
      {next_save, next_use_plist} = {save_params_out, use_plist_out};
      unique case (state)
         ST_IDLE: begin
            if (start_in) begin
               next_err = 1'b0;
               next_check_cond = 1'b0;
               next_acc = 64'h0;
               next_byte_cnt = 16'h0;
               next_desc_cnt = 11'h0;
               next_rep_idx = 11'h0;
               next_rep_phase = 1'b0;
               next_imm = immed_in;
               next_dfmt = dlist_fmt_in;
               next_pattern_mode = 1'b0;
               next_pattern_len = 16'h0;
               next_pi_interval = blk_len >> interval_exp_in;
               next_remain = dlist_len_in;
               next_skip_pl = param_list_present_flag_in && skip_primary_list_flag_in;
               next_save = !(param_list_present_flag_in && disable_save_in);
               next_use_plist = !next_skip_pl;
               if (!param_list_present_flag_in) begin
                  next_remain = 16'h0;
                  next_state = ST_REPLAY;
               end else begin
                  if (prot_type_in == PROT_T1 && interval_exp_in != 4'h0)
                     next_err = 1'b1;
                  if (prot_type_in == PROT_T2 && interval_exp_in != 4'h0
                     && !(interval_exp_in == PIE_4K && blk_log2 == BLK_LOG2_4K))
                     next_err = 1'b1;
                  if (prot_type_in > PROT_T2)
                     next_err = 1'b1;
                  if (dlist_len_in != 16'h0 && (!fmt_ok(dlist_fmt_in)
                     || dlist_len_in[1:0] != 2'h0
                     || (dlist_fmt_in != DFMT_BLOCK && dlist_len_in[2] != 1'b0)))
                     next_err = 1'b1;
                  if ((dlist_len_in >> (dlist_fmt_in == DFMT_BLOCK ? 2 : 3))
                     > {5'h0, MAX_DESCS})
                     next_err = 1'b1;
                  if (next_err)
                     next_state = ST_DRAIN;
                  else if (pattern_descriptor_flag_in)
                     next_state = ST_PAT_HDR;
                  else if (dlist_len_in != 16'h0)
                     next_state = ST_DEFECT;
                  else
                     next_state = ST_DRAIN;
               end
            end
         end
         ST_PAT_HDR: if (byte_valid_in) begin
            next_acc = {acc[55:0], byte_in};
            next_byte_cnt = byte_cnt + 16'h1;
            if (byte_cnt == 16'h1)
               next_pattern_mode = (byte_in == PAT_REPEAT);
            if (byte_cnt == {13'h0, PAT_HDR_BYTES} - 16'h1) begin
               next_byte_cnt = 16'h0;
               next_pattern_len = plen_now;
               if (acc[15:8] != PAT_DEFAULT && acc[15:8] != PAT_REPEAT)
                  next_err = 1'b1;
               if (acc[15:8] == PAT_DEFAULT && plen_now != 16'h0)
                  next_err = 1'b1;
               if (acc[15:8] == PAT_REPEAT && plen_now == 16'h0)
                  next_err = 1'b1;
               if (plen_now > blk_len)
                  next_err = 1'b1;
               if (next_err || (byte_last_in && plen_now != 16'h0))
                  next_state = ST_DRAIN;
               else if (plen_now != 16'h0)
                  next_state = ST_PAT_DATA;
               else if (remain != 16'h0)
                  next_state = ST_DEFECT;
               else
                  next_state = ST_DRAIN;
            end
            if (byte_last_in) begin
               next_err = next_err || (next_state != ST_DRAIN);
               next_state = ST_REPORT;
            end
         end
         ST_PAT_DATA: if (byte_valid_in) begin
            next_pat_bv = 1'b1;
            next_pat_byte = byte_in;
            next_byte_cnt = byte_cnt + 16'h1;
            if (byte_cnt + 16'h1 == pattern_len_out) begin
               next_byte_cnt = 16'h0;
               next_state = (remain != 16'h0) ? ST_DEFECT : ST_DRAIN;
            end
            if (byte_last_in) begin
               next_err = (next_state != ST_DRAIN);
               next_state = ST_REPORT;
            end
         end
         ST_DEFECT: if (byte_valid_in) begin
            next_acc = {acc[55:0], byte_in};
            next_byte_cnt = byte_cnt + 16'h1;
            next_remain = remain - 16'h1;
            if (byte_cnt == {12'h0, dbytes} - 16'h1) begin
               next_byte_cnt = 16'h0;
               mem_we = 1'b1;
               if (dfmt == DFMT_BYTES)
                  mem_wdata = {desc_now[63:32], off_sector};
               else
                  mem_wdata = (dfmt == DFMT_BLOCK) ? {32'h0, desc_now[31:0]} : desc_now;
               next_desc_cnt = desc_cnt + 11'h1;
               if (desc_bad) begin
                  next_err = 1'b1;
                  next_state = ST_DRAIN;
               end
            end
            if (byte_last_in) begin
               if (next_remain != 16'h0 || next_byte_cnt != 16'h0)
                  next_err = 1'b1;
               next_state = ST_REPORT;
            end else if (next_remain == 16'h0 && !next_err)
               next_state = ST_DRAIN;
         end
         ST_DRAIN: if (byte_valid_in) begin
            next_err = 1'b1;
            if (byte_last_in)
               next_state = ST_REPORT;
         end
         ST_REPORT: begin
            if (err) begin
               next_status_valid = 1'b1;
               next_check_cond = 1'b1;
               next_state = ST_IDLE;
            end else
               next_state = ST_REPLAY;
         end
         ST_REPLAY: begin
            if (rep_idx == desc_cnt) begin
               next_format_start = 1'b1;
               next_status_valid = imm;
               next_state = ST_FORMAT;
            end else if (!rep_phase) begin
               next_defect_valid = 1'b1;
               next_defect_key = rd_desc;
               next_rep_phase = 1'b1;
            end else if (!defect_valid_out) begin
               // Lookup answer arrives one cycle after the key
               next_grown_add = !(skip_pl && plist_hit_in);
               next_rep_phase = 1'b0;
               next_rep_idx = rep_idx + 11'h1;
            end
         end
         ST_FORMAT: begin
            if (format_done_in || format_fail_in) begin
               next_state = ST_IDLE;
               if (imm)
                  next_deferred = format_fail_in;
               else begin
                  next_status_valid = 1'b1;
                  next_check_cond = format_fail_in;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (mem_we)
         desc_mem[desc_cnt[9:0]] <= mem_wdata;
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state <= ST_IDLE;
         {err, rep_phase, skip_pl, imm} <= 4'h0;
         {acc, defect_key_out} <= 128'h0;
         {byte_cnt, remain, pattern_len_out, pi_interval_out} <= 64'h0;
         {desc_cnt, rep_idx} <= 22'h0;
         {dfmt, defect_fmt_out} <= {DFMT_BLOCK, DFMT_BLOCK};
         {pattern_mode_out, pattern_byte_valid_out, defect_valid_out, grown_add_out} <= 4'h0;
         {format_start_out, status_valid_out, check_cond_out, deferred_err_out} <= 4'h0;
         {use_plist_out, save_params_out} <= 2'b11;
         {pattern_byte_out, asc_out, sense_key_out} <= 20'h0;
      end else begin
         state <= next_state;
         {err, rep_phase, skip_pl, imm} <= {next_err, next_rep_phase, next_skip_pl, next_imm};
         {acc, defect_key_out} <= {next_acc, next_defect_key};
         {byte_cnt, remain} <= {next_byte_cnt, next_remain};
         {pattern_len_out, pi_interval_out} <= {next_pattern_len, next_pi_interval};
         {desc_cnt, rep_idx} <= {next_desc_cnt, next_rep_idx};
         {dfmt, defect_fmt_out} <= {next_dfmt, next_dfmt};
         {pattern_mode_out, pattern_byte_valid_out} <= {next_pattern_mode, next_pat_bv};
         {defect_valid_out, grown_add_out} <= {next_defect_valid, next_grown_add};
         {format_start_out, status_valid_out} <= {next_format_start, next_status_valid};
         {check_cond_out, deferred_err_out} <= {next_check_cond, next_deferred};
         {use_plist_out, save_params_out} <= {next_use_plist, next_save};
         pattern_byte_out <= next_pat_byte;
         // Illegal request sense only for parameter faults
         sense_key_out <= (next_check_cond && err) ? SK_ILLEGAL_REQUEST : 4'h0;
         asc_out <= (next_check_cond && err) ? ASC_INV_FIELD_PLIST : 8'h0;
      end
   end
endmodule

// *** verif/fplc_checker_asserts.sv ***
// Port assertions of the format parameter list checker.
// Assumes one clock domain; bound to every checker instance.
`timescale 1ns/1ns
module fplc_checker_asserts
   import fplc_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic start_in,
   input wire logic immed_in,
   input wire logic disable_save_in,
   input wire logic skip_primary_list_flag_in,
   input wire logic plist_hit_in,
   input wire logic format_fail_in,
   input wire logic defect_valid_out,
   input wire logic grown_add_out,
   input wire logic use_plist_out,
   input wire logic save_params_out,
   input wire logic format_start_out,
   input wire logic status_valid_out,
   input wire logic check_cond_out,
   input wire logic [3:0] sense_key_out,
   input wire logic deferred_err_out
);
   logic immed_q, save_q, skip_q, started_q;
   // ==========
   // Flags of the running command
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         {immed_q, save_q, skip_q, started_q} <= 4'h0;
      end else if (start_in) begin
         {immed_q, save_q, skip_q} <= {immed_in, disable_save_in, skip_primary_list_flag_in};
         started_q <= 1'b0;
      end else if (format_start_out) begin
         started_q <= 1'b1;
      end
   end
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   // ==========
   // Properties
   sequence s_kept; defect_valid_out ##1 !plist_hit_in; endsequence
   sequence s_dropped; defect_valid_out ##1 (plist_hit_in && !use_plist_out); endsequence
   property p_kept; s_kept |=> grown_add_out; endproperty
   a_kept: assert property (p_kept) else $error("grown add missing");
   property p_dropped; s_dropped |=> !grown_add_out; endproperty
   a_dropped: assert property (p_dropped) else $error("factory entry added");
   property p_once; status_valid_out |=> !status_valid_out; endproperty
   a_once: assert property (p_once) else $error("status repeated");
   property p_early; format_start_out && immed_q |-> status_valid_out; endproperty
   a_early: assert property (p_early) else $error("early status missing");
   property p_defer; deferred_err_out |-> immed_q && $past(format_fail_in); endproperty
   a_defer: assert property (p_defer) else $error("deferred error uncaused");
   property p_save; format_start_out |-> save_params_out != save_q; endproperty
   a_save: assert property (p_save) else $error("save flag wrong");
   property p_plist; format_start_out |-> use_plist_out != skip_q; endproperty
   a_plist: assert property (p_plist) else $error("factory list use wrong");
   property p_first; status_valid_out && sense_key_out == SK_ILLEGAL_REQUEST |->
      check_cond_out && !started_q; endproperty
   a_first: assert property (p_first) else $error("media run before error");
endmodule
bind fplc_checker fplc_checker_asserts fplc_checker_asserts_inst (.*);

// *** verif/fplc_initiator.sv ***
// Initiator and media side model: streams list bytes, answers lookups.
// Assumes the bench calls send() and sets factory_key and fail_next.
`timescale 1ns/1ns
module fplc_initiator (
   input wire logic ref_clk_in,
   input wire logic key_valid_in,
   input wire logic [63:0] key_in,
   input wire logic fmt_start_in,
   output logic data_valid_out = 1'b0,
   output logic [7:0] data_out = 8'h00,
   output logic data_last_out = 1'b0,
   output logic hit_out = 1'b0,
   output logic done_out = 1'b0,
   output logic fail_out = 1'b0
);
   logic [63:0] factory_key = '1;
   logic fail_next = 1'b0;
   int wait_cnt = 0;
   // Bytes only in the data out phase, with random stalls
   task automatic send(input logic [7:0] d[$]);
      foreach (d[i]) begin
         @(posedge ref_clk_in);
         if ($urandom % 3 == 0) begin
            data_valid_out <= 1'b0;
            data_out <= ~data_out;
            @(posedge ref_clk_in);
         end
         data_valid_out <= 1'b1;
         data_out <= d[i];
         data_last_out <= (i == d.size() - 1);
      end
      @(posedge ref_clk_in);
      data_valid_out <= 1'b0;
      data_last_out <= 1'b0;
      data_out <= ~data_out;
   endtask
   always @(posedge ref_clk_in) begin
      hit_out <= key_valid_in && key_in === factory_key;
      done_out <= 1'b0;
      fail_out <= 1'b0;
      if (fmt_start_in) begin
         wait_cnt <= 3 + $urandom % 8;
      end else if (wait_cnt == 1) begin
         done_out <= !fail_next;
         fail_out <= fail_next;
         wait_cnt <= 0;
      end else if (wait_cnt > 1) begin
         wait_cnt <= wait_cnt - 1;
      end
   end
endmodule

// *** verif/fplc_checker_bench.sv ***
// Self-checking bench of the format parameter list checker.
// Assumes the initiator model and the bound assertion checker.
`timescale 1ns/1ns
module fplc_checker_bench;
   import fplc_pkg::*;
   logic clk, rst_n, wr, rd, start, pres, pat, skip, dsave, immed, bv, bl, hit, done, fail;
   logic dv, ga, fs, sv, cc, de, pm, up, sp;
   logic [7:0] addr, b, asc, q[$];
   logic [31:0] wdata, rdata, lba;
   logic [1:0] pt;
   logic [3:0] ie, sk;
   logic [2:0] df;
   logic [15:0] dl, plen, piv;
   logic [63:0] key, fkey, exp_key[$];
   logic [12:0] exp_st[$];
   int fail_count, checks_done, grown, defer;
   fplc_checker fplc_checker_inst (.ref_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .start_in(start), .param_list_present_flag_in(pres), .pattern_descriptor_flag_in(pat),
      .skip_primary_list_flag_in(skip), .disable_save_in(dsave), .immed_in(immed),
      .prot_type_in(pt), .interval_exp_in(ie), .dlist_fmt_in(df), .dlist_len_in(dl),
      .byte_valid_in(bv), .byte_in(b), .byte_last_in(bl), .plist_hit_in(hit),
      .format_done_in(done), .format_fail_in(fail), .pattern_mode_out(pm),
      .pattern_len_out(plen), .pattern_byte_valid_out(), .pattern_byte_out(),
      .pi_interval_out(piv), .defect_valid_out(dv), .defect_fmt_out(), .defect_key_out(key),
      .grown_add_out(ga), .use_plist_out(up), .save_params_out(sp), .format_start_out(fs),
      .status_valid_out(sv), .check_cond_out(cc), .sense_key_out(sk), .asc_out(asc),
      .deferred_err_out(de));
   fplc_initiator fplc_initiator_inst (.ref_clk_in(clk), .key_valid_in(dv), .key_in(key),
      .fmt_start_in(fs), .data_valid_out(bv), .data_out(b), .data_last_out(bl),
      .hit_out(hit), .done_out(done), .fail_out(fail));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========
   // Tasks
   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
      checks_done++;
      if (s !== e) begin
         $display("[ERR] %s exp %h got %h", n, e, s);
         fail_count++;
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      {addr, rd} <= {a, 1'b1};
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", rdata, e);
   endtask
   task automatic p32(input logic [31:0] v);
      for (int i = 3; i >= 0; i--) q.push_back(v[i*8 +: 8]);
   endtask
   task automatic cmd(input logic [4:0] fl, input logic [1:0] t, input logic [3:0] e,
      input logic [2:0] f, input logic [15:0] n, input logic err);
      exp_st.push_back(err ? {1'b1, SK_ILLEGAL_REQUEST, ASC_INV_FIELD_PLIST} : 13'h0);
      @(posedge clk);
      {pres, pat, skip, dsave, immed, pt, ie, df, dl, start} <= {fl, t, e, f, n, 1'b1};
      @(posedge clk);
      start <= 1'b0;
      fplc_initiator_inst.send(q);
      for (int i = 0; i < 3000 && exp_st.size() > 0; i++) @(posedge clk);
      if (exp_st.size() > 0) begin
         fail_count++;
         conclude();
      end
      q.delete();
      repeat (20) @(posedge clk);
   endtask
   // ==========
   // Result watcher
   always @(posedge clk) begin
      if (sv && exp_st.size() == 0) chk("status", 1, 0);
      else if (sv) chk("status", {cc, sk, asc}, exp_st.pop_front());
      if (dv && exp_key.size() == 0) chk("key", 1, 0);
      else if (dv) chk("key", key, exp_key.pop_front());
      grown <= grown + ga;
      defer <= defer + de;
   end
   // ==========
   // Scenarios
   initial begin
      {rst_n, wr, rd, start, addr, wdata, pres, pat, skip, dsave, immed} = '0;
      {pt, ie, df, dl, fail_count, checks_done, grown, defer} = '0;
      void'($urandom(32'hb6ba));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rreg(REG_STATUS, 32'h1);
      rreg(REG_MAX_LBA, MAX_LBA_RST);
      rreg(8'h20, 32'h0);
      lba = $urandom;
      q = '{8'h00, PAT_REPEAT, 8'h00, 8'h02, 8'haa, 8'h55};
      p32(lba);
      p32(lba >> 4);
      exp_key = '{{32'h0, lba}, {32'h0, lba >> 4}};
      cmd(5'b11001, PROT_T0, 4'h0, DFMT_BLOCK, 16'h8, 1'b0);
      chk("pmode", pm, 1'b1);
      chk("plen", plen, 16'h2);
      q = '{8'h00, PAT_DEFAULT, 8'h00, 8'h01, 8'haa};
      cmd(5'b11000, PROT_T0, 4'h0, DFMT_BLOCK, 16'h0, 1'b1);
      q = '{8'h00, PAT_REPEAT, 8'h00, 8'h00};
      cmd(5'b11000, PROT_T0, 4'h0, DFMT_BLOCK, 16'h0, 1'b1);
      p32(32'h5);
      cmd(5'b10000, PROT_T1, 4'h1, DFMT_BLOCK, 16'h4, 1'b1);
      p32(32'h5);
      cmd(5'b10000, PROT_T2, PIE_4K, DFMT_BLOCK, 16'h4, 1'b1);
      wreg(REG_CFG, {28'h0, BLK_LOG2_4K});
      p32(32'h7);
      exp_key = '{64'h7};
      cmd(5'b10001, PROT_T2, PIE_4K, DFMT_BLOCK, 16'h4, 1'b0);
      chk("interval", piv, 16'd512);
      wreg(REG_CFG, 32'h9);
      q = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02};
      cmd(5'b10000, PROT_T0, 4'h0, DFMT_BLOCK, 16'h6, 1'b1);
      p32(32'h1);
      cmd(5'b10000, PROT_T0, 4'h0, DFMT_BLOCK, 16'd4100, 1'b1);
      wreg(REG_MAX_LBA, 32'd100);
      for (int v = 100; v <= 101; v++) begin
         p32(v);
         if (v == 100) exp_key.push_back(64'd100);
         cmd(5'b10000, PROT_T0, 4'h0, DFMT_BLOCK, 16'h4, v == 101);
      end
      p32({24'h000123, 8'h04});
      p32(32'h1234);
      fkey = {24'h000123, 8'h04, 32'h9};
      exp_key = '{fkey};
      fplc_initiator_inst.factory_key = fkey;
      cmd(5'b10110, PROT_T0, 4'h0, DFMT_BYTES, 16'h8, 1'b0);
      chk("use_plist", up, 1'b0);
      chk("save", sp, 1'b0);
      chk("pmode", pm, 1'b0);
      chk("grown", grown, 4);
      p32({24'h000010, 8'h01});
      p32(32'h20);
      exp_key = '{{24'h000010, 8'h01, 32'h20}};
      fplc_initiator_inst.fail_next = 1'b1;
      cmd(5'b10001, PROT_T0, 4'h0, DFMT_PHYS, 16'h8, 1'b0);
      chk("deferred", defer, 1);
      chk("grown", grown, 5);
      chk("keys left", exp_key.size(), 0);
      conclude();
   end
endmodule
